// ---- idc_pkg.sv ----
// shared constants for the interrupt daisy chain and its acknowledging host
// assumes both ends are clocked by the same board clock mclk
package idc_pkg;
    // ------------------------------------------------------------
    // chain layout
    // ------------------------------------------------------------
    localparam int IDC_NUM_CIO = 5; // counter/io sub-sources
    localparam int IDC_NUM_CHAN = 10; // serial channels 0..9
    localparam int IDC_NUM_SRC = 15; // total chain positions
    localparam int IDC_NUM_CHIP = 6; // counter/io chip plus five serial controllers
    localparam int IDC_CAUSE_W = 2; // serial cause code width
    // counter/io positions, highest first
    localparam logic [2:0] IDC_CIO_CT3 = 3'h0;
    localparam logic [2:0] IDC_CIO_PIN = 3'h1;
    localparam logic [2:0] IDC_CIO_CT2 = 3'h2;
    localparam logic [2:0] IDC_CIO_POUT = 3'h3;
    localparam logic [2:0] IDC_CIO_CT1 = 3'h4;
    // ------------------------------------------------------------
    // vector space
    // ------------------------------------------------------------
    localparam logic [7:0] IDC_VEC_FIRST_FREE = 8'h20; // 0..31 belong to the processor
    localparam logic [7:0] IDC_VEC_ERR_TRAP = 8'hFF; // failed vector path reads all ones
    localparam logic [7:0] IDC_VEC_RST = 8'h20; // base vector after reset
    // ------------------------------------------------------------
    // programming selects on the link
    // ------------------------------------------------------------
    localparam logic [2:0] IDC_SEL_CTRL = 3'h6; // bit 0: status affects vector
    // ------------------------------------------------------------
    // host command port offsets
    // ------------------------------------------------------------
    localparam logic [3:0] IDC_REG_CTRL = 4'h6;
    localparam logic [3:0] IDC_REG_EOI = 4'h7;
    localparam logic [3:0] IDC_REG_STAT = 4'h8;
    localparam logic [3:0] IDC_REG_VEC = 4'h9;
    localparam logic [3:0] IDC_REG_CNT = 4'hA;
    localparam int IDC_STAT_ERR = 0; // refused vector write, write 1 to clear
    localparam int IDC_STAT_SERVE = 1;
    localparam int IDC_STAT_REQ = 2;
endpackage

// ---- idc_link_if.sv ----
// link between the daisy chain (device end) and the acknowledging host
// assumes a single shared clock; every signal is synchronous to mclk
`timescale 1ns/10ps
interface idc_link_if;
    logic int_req; // level: chain has an enabled pending source
    logic iack; // pulse: host acknowledge
    logic vec_valid; // pulse: vector on vec
    logic [7:0] vec; // vector byte
    logic eoi; // pulse: end of service of highest in-service source
    logic prog_we; // pulse: vector/control write
    logic [2:0] prog_sel; // chip 0..5 or control
    logic [7:0] prog_data;
    modport dev (output int_req, output vec_valid, output vec,
                 input iack, input eoi, input prog_we, input prog_sel, input prog_data);
    modport host (input int_req, input vec_valid, input vec,
                  output iack, output eoi, output prog_we, output prog_sel, output prog_data);
endinterface

// ---- idc_chain.sv ----
// device end: interrupt priority daisy chain with vectoring and board jumpers
// assumes source requests are one-cycle pulses synchronous to mclk
//
// Notes on behaviour
// - counter/io chip first: ct3, in, ct2, out, ct1
// - controller zero second: channel 9 before 8
// - controller one third: channel 7 before 6
// - controller two fourth: channel 5 before 4
// - controller three fifth: channel 3 before 2
// - controller four last: channel 1, then 0
// - each chip returns its own programmed vector
// - status-affects-vector folds cause into vector
// - host takes one vector per acknowledge
// - vectors 0 to 4 are processor's own
// - vectors 5 to 31 are reserved
// - vector 255 kept as hardware error trap; with status-affects-vector, a base of F8..FE can still fold to 255
// - jumper selects channel attention port number
// - jumper selects driven bus interrupt level
// - priority in/out jumpers place board in arbitration
// - jumper enables early memory acknowledge
// - master jumper only on master board
`timescale 1ns/10ps
module idc_chain
    import idc_pkg::*;
#(
    parameter int PORT_W = 4, // channel attention port number width
    parameter int LEVEL_W = 3 // bus interrupt level select width
)
(
    input wire logic mclk,
    input wire logic rst_b,
    idc_link_if.dev link,
    input wire logic [IDC_NUM_CIO-1:0] cio_req,
    input wire logic [IDC_NUM_CHAN-1:0] chan_req,
    input wire logic [IDC_NUM_CHAN*IDC_CAUSE_W-1:0] chan_cause,
    input wire logic attn_strobe,
    input wire logic [PORT_W-1:0] attn_port,
    input wire logic [PORT_W-1:0] attention_port_jumper,
    output logic channel_attention,
    input wire logic sys_int_req,
    input wire logic [LEVEL_W-1:0] bus_irq_level_jumper,
    output logic [(1<<LEVEL_W)-1:0] bus_irq,
    input wire logic bus_req,
    input wire logic bus_priority_in,
    output logic bus_priority_out,
    output logic bus_grant,
    input wire logic early_memory_acknowledge,
    input wire logic normal_mem_ack,
    input wire logic early_ack_jumper,
    output logic mem_ack,
    input wire logic master_board_jumper,
    output logic is_master
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (PORT_W < 1 || PORT_W > 16 || LEVEL_W < 1 || LEVEL_W > 4)
    begin : g_bad_param
        $error("port or level width out of range");
    end

    // ------------------------------------------------------------
    // vector arithmetic
    // ------------------------------------------------------------
    // chain position to chip index: 0 counter/io, 1..5 serial controllers
    function automatic logic [2:0] chip_of(input int pos);
        return (pos < IDC_NUM_CIO) ? 3'h0 : 3'((pos - IDC_NUM_CIO) / 2 + 1);
    endfunction

    // vector for a position; cause bits replace the low bits when enabled
    function automatic logic [7:0] vec_of(input int pos, input logic [7:0] base,
                                          input logic [IDC_CAUSE_W-1:0] cause,
                                          input logic sav);
        // unfolded: one vector per chip; folded: sub-source, or channel b flag and cause
        return sav ? {base[7:3], (pos < IDC_NUM_CIO) ? 3'(pos) : {1'(pos - IDC_NUM_CIO), cause}}
                   : base;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [IDC_NUM_SRC-1:0] pend_ff; // pending requests, chain order
    logic [IDC_NUM_SRC-1:0] srv_ff; // under service
    logic [IDC_CAUSE_W-1:0] cause_ff [IDC_NUM_SRC]; // cause latched with request
    logic [7:0] base_ff [IDC_NUM_CHIP]; // programmed chip vectors
    logic sav_ff; // status affects vector
    logic [7:0] vec_ff;
    logic vec_valid_ff;
    logic attn_ff;
    logic [(1<<LEVEL_W)-1:0] irq_ff;
    logic master_ff;

    // ------------------------------------------------------------
    // request mapping into chain order
    // ------------------------------------------------------------
    logic attn_hit; // attention aimed at this board's port
    logic [IDC_NUM_SRC-1:0] src_req; // new requests, chain order
    logic [IDC_CAUSE_W-1:0] src_cause [IDC_NUM_SRC];
    assign attn_hit = attn_strobe && (attn_port == attention_port_jumper);
    // attention arrives through the counter/io input port
    assign src_req[IDC_CIO_CT3] = cio_req[0];
    assign src_req[IDC_CIO_PIN] = cio_req[1] | attn_hit;
    assign src_req[IDC_CIO_CT2] = cio_req[2];
    assign src_req[IDC_CIO_POUT] = cio_req[3];
    assign src_req[IDC_CIO_CT1] = cio_req[4];

    genvar g;
    generate
        for (g = 0; g < IDC_NUM_CIO; g++)
        begin : g_cio_cause
            assign src_cause[g] = '0;
        end
        // position 5+k is channel 9-k: controller zero a/b first, controller four last
        for (g = 0; g < IDC_NUM_CHAN; g++)
        begin : g_chan
            assign src_req[IDC_NUM_CIO+g] = chan_req[IDC_NUM_CHAN-1-g];
            assign src_cause[IDC_NUM_CIO+g] =
                chan_cause[(IDC_NUM_CHAN-1-g)*IDC_CAUSE_W +: IDC_CAUSE_W];
        end
    endgenerate

    // ------------------------------------------------------------
    // priority enable chain
    // ------------------------------------------------------------
    // en[i] is high only when every higher source is idle
    logic [IDC_NUM_SRC:0] prio_en;
    logic [IDC_NUM_SRC-1:0] ack_pick; // one-hot winner of an acknowledge
    logic [IDC_NUM_SRC-1:0] eoi_pick; // one-hot highest in-service source
    logic [IDC_NUM_SRC:0] srv_free; // no higher source in service
    assign prio_en[0] = 1'b1;
    assign srv_free[0] = 1'b1;
    generate
        for (g = 0; g < IDC_NUM_SRC; g++)
        begin : g_daisy
            assign prio_en[g+1] = prio_en[g] & ~pend_ff[g] & ~srv_ff[g];
            assign ack_pick[g] = link.iack & prio_en[g] & pend_ff[g];
            assign srv_free[g+1] = srv_free[g] & ~srv_ff[g];
            assign eoi_pick[g] = link.eoi & srv_free[g] & srv_ff[g];
        end
    endgenerate
    // request goes out only for a pending source whose enable is high
    assign link.int_req = |(pend_ff & prio_en[IDC_NUM_SRC-1:0]);

    // ------------------------------------------------------------
    // next vector
    // ------------------------------------------------------------
    logic [7:0] nxt_vec;
    always_comb
    begin
        // no winner returns the error trap code, as a broken vector path would
        nxt_vec = IDC_VEC_ERR_TRAP;
        for (int i = 0; i < IDC_NUM_SRC; i++)
        begin
            if (ack_pick[i])
            begin
                nxt_vec = vec_of(i, base_ff[chip_of(i)], cause_ff[i], sav_ff);
            end
        end
    end

    // ------------------------------------------------------------
    // pending and in-service flags
    // ------------------------------------------------------------
    // a new request in the acknowledge cycle stays pending: set wins
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_ff <= '0;
            srv_ff <= '0;
        end
        else
        begin
            pend_ff <= (pend_ff & ~ack_pick) | src_req;
            srv_ff <= (srv_ff & ~eoi_pick) | ack_pick;
        end
    end

    // cause captured only when a request finds its source not pending, or being acknowledged
    logic [IDC_NUM_SRC-1:0] cause_take; // request that opens a new pending period
    assign cause_take = src_req & (~pend_ff | ack_pick);
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < IDC_NUM_SRC; i++)
            begin
                cause_ff[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < IDC_NUM_SRC; i++)
            begin
                cause_ff[i] <= cause_take[i] ? src_cause[i] : cause_ff[i];
            end
        end
    end

    // ------------------------------------------------------------
    // programming from the host
    // ------------------------------------------------------------
    // the device stores what it is given; the host screens reserved codes
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < IDC_NUM_CHIP; i++)
            begin
                base_ff[i] <= IDC_VEC_RST;
            end
            sav_ff <= 1'b0;
        end
        else if (link.prog_we)
        begin
            if (link.prog_sel == IDC_SEL_CTRL)
            begin
                sav_ff <= link.prog_data[0];
            end
            else if (link.prog_sel < 3'(IDC_NUM_CHIP))
            begin
                base_ff[link.prog_sel] <= link.prog_data;
            end
        end
    end

    // ------------------------------------------------------------
    // acknowledge answer: vector one cycle after iack
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vec_ff <= '0;
            vec_valid_ff <= 1'b0;
        end
        else
        begin
            vec_valid_ff <= link.iack;
            vec_ff <= link.iack ? nxt_vec : vec_ff; // held until the next acknowledge
        end
    end
    assign link.vec = vec_ff;
    assign link.vec_valid = vec_valid_ff;

    // ------------------------------------------------------------
    // board jumpers and system bus side
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            attn_ff <= 1'b0;
            irq_ff <= '0;
            master_ff <= 1'b0;
        end
        else
        begin
            attn_ff <= attn_hit;
            irq_ff <= sys_int_req ? ((1<<LEVEL_W)'(1) << bus_irq_level_jumper) : '0;
            master_ff <= master_board_jumper;
        end
    end
    assign channel_attention = attn_ff;
    assign bus_irq = irq_ff;
    assign is_master = master_ff;
    // arbitration: take the bus only with priority in, pass it down otherwise
    assign bus_grant = bus_priority_in & bus_req;
    assign bus_priority_out = bus_priority_in & ~bus_req;
    // early acknowledge shortens memory waits when fitted
    assign mem_ack = early_ack_jumper ? early_memory_acknowledge : normal_mem_ack;
endmodule

// ---- idc_host.sv ----
// host end: acknowledges the chain, collects vectors, screens programming
// assumes a plain command port: read data stands one cycle after read strobe
`timescale 1ns/10ps
module idc_host
    import idc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    idc_link_if.host link,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    // ------------------------------------------------------------
    // acknowledge sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        IDC_IDLE = 4'b0001, // waiting for a request
        IDC_ACK = 4'b0010, // iack out this cycle
        IDC_WAIT = 4'b0100, // vector due
        IDC_SERVE = 4'b1000 // software servicing, awaiting eoi
    } idc_hst_t;
    idc_hst_t st_ff;
    idc_hst_t nxt_st;

    logic err_ff; // refused vector write, sticky
    logic [7:0] vec_ff; // last vector taken
    logic [7:0] cnt_ff; // acknowledges done
    logic [7:0] rdata_ff;
    logic prog_we_ff;
    logic [2:0] prog_sel_ff;
    logic [7:0] prog_data_ff;
    logic eoi_ff;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic wr_chip; // vector write to a chip
    logic bad_vec; // code in the processor's own or reserved range, or the trap
    logic wr_eoi;
    logic wr_clr;
    assign wr_chip = wr && (addr < 4'(IDC_NUM_CHIP));
    assign bad_vec = (wdata < IDC_VEC_FIRST_FREE) || (wdata == IDC_VEC_ERR_TRAP);
    assign wr_eoi = wr && (addr == IDC_REG_EOI) && (st_ff == IDC_SERVE);
    assign wr_clr = wr && (addr == IDC_REG_STAT) && wdata[IDC_STAT_ERR];

    always_comb
    begin
        nxt_st = st_ff;
        unique case (st_ff)
            IDC_IDLE: if (link.int_req) nxt_st = IDC_ACK;
            IDC_ACK: nxt_st = IDC_WAIT;
            IDC_WAIT: if (link.vec_valid) nxt_st = IDC_SERVE;
            IDC_SERVE: if (wr_eoi) nxt_st = IDC_IDLE;
            default: nxt_st = IDC_IDLE; // illegal code recovers
        endcase
    end

    // one vector per acknowledge, kept until the next
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= IDC_IDLE;
            vec_ff <= '0;
            cnt_ff <= '0;
            eoi_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            eoi_ff <= wr_eoi;
            if (st_ff == IDC_WAIT && link.vec_valid)
            begin
                vec_ff <= link.vec;
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end
    assign link.iack = (st_ff == IDC_ACK);
    assign link.eoi = eoi_ff;

    // ------------------------------------------------------------
    // programming path, reserved codes refused
    // ------------------------------------------------------------
    // set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prog_we_ff <= 1'b0;
            prog_sel_ff <= '0;
            prog_data_ff <= '0;
            err_ff <= 1'b0;
        end
        else
        begin
            prog_we_ff <= (wr_chip && !bad_vec) || (wr && addr == IDC_REG_CTRL);
            prog_sel_ff <= (addr == IDC_REG_CTRL) ? IDC_SEL_CTRL : addr[2:0];
            prog_data_ff <= wdata;
            err_ff <= (wr_chip && bad_vec) || (err_ff && !wr_clr);
        end
    end
    assign link.prog_we = prog_we_ff;
    assign link.prog_sel = prog_sel_ff;
    assign link.prog_data = prog_data_ff;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    assign rd_mux = (addr == IDC_REG_STAT) ?
                    {5'h00, link.int_req, st_ff == IDC_SERVE, err_ff} :
                    (addr == IDC_REG_VEC) ? vec_ff :
                    (addr == IDC_REG_CNT) ? cnt_ff : 8'h00;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= rd ? rd_mux : 8'h00;
        end
    end
    assign rdata = rdata_ff;
endmodule

// ---- idc_monitor.sv ----
// checker for the link between the daisy chain and its acknowledging host
// assumes one board clock and an asynchronous active-low reset
`timescale 1ns/10ps
module idc_monitor
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic int_req,
    input wire logic iack,
    input wire logic vec_valid,
    input wire logic [7:0] vec,
    input wire logic eoi,
    input wire logic prog_we,
    input wire logic [2:0] prog_sel,
    input wire logic [7:0] prog_data
);
    // ------------------------------------------------------------
    // one domain, so one default clock and reset
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // every acknowledge is answered by a vector exactly one cycle later
    property p_ack_answer; iack |=> vec_valid; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("vector late");
    // a vector never appears without its own acknowledge
    property p_vec_cause; vec_valid |-> $past(iack); endproperty
    a_vec_cause: assert property (p_vec_cause) else $error("stray vector");
    // acknowledge is a single-cycle pulse, so one vector each
    property p_iack_pulse; iack |=> !iack; endproperty
    a_iack_pulse: assert property (p_iack_pulse) else $error("long acknowledge");
    // no new acknowledge in the two cycles after a vector is delivered
    property p_hold_service; vec_valid |=> !iack [*2]; endproperty
    a_hold_service: assert property (p_hold_service) else $error("early acknowledge");
    // the host only acknowledges a request that the chain raised
    property p_ack_needs_req; iack |-> $past(int_req); endproperty
    a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");
    // the vector byte only moves when a new vector is delivered
    property p_vec_holds; $changed(vec) |-> vec_valid; endproperty
    a_vec_holds: assert property (p_vec_holds) else $error("vector moved");
    // processor-owned and reserved codes never reach a chip
    property p_no_proc_vec; prog_we && prog_sel < 3'h6 |-> prog_data >= 8'h20; endproperty
    a_no_proc_vec: assert property (p_no_proc_vec) else $error("reserved code");
    // the all-ones trap code is never programmed
    property p_no_trap; prog_we && prog_sel < 3'h6 |-> prog_data != 8'hFF; endproperty
    a_no_trap: assert property (p_no_trap) else $error("trap code programmed");
    // end of service is a single-cycle pulse
    property p_eoi_pulse; eoi |=> !eoi; endproperty
    a_eoi_pulse: assert property (p_eoi_pulse) else $error("long end of service");
endmodule

// ---- idc_tb.sv ----
// self-checking bench: chain and host joined by the link, with a queue-free model
// assumes a 50 ns board clock; the host command port is the only bus
`timescale 1ns/10ps
module idc_tb;
    import idc_pkg::*;
    logic mclk, rst_b, wr, rd, attn_strobe, sys_int_req, bus_req, bus_priority_in;
    logic early_memory_acknowledge, normal_mem_ack, early_ack_jumper, master_board_jumper;
    logic channel_attention, bus_priority_out, bus_grant, mem_ack, is_master;
    logic [3:0] addr, attn_port, attention_port_jumper;
    logic [7:0] wdata, rdata, bus_irq, lastv;
    logic [7:0] base [6]; // model copy of each chip's base vector
    logic [7:0] bad [3] = '{8'h04, 8'h1F, 8'hFF}; // codes the host must refuse
    logic [2:0] bus_irq_level_jumper;
    logic [4:0] cio_req;
    logic [9:0] chan_req;
    logic [19:0] chan_cause;
    bit pend [15]; // model pending flags, chain order
    bit sav; // model status-affects-vector
    int fail_count, compares, acks;
    idc_link_if link ();
    idc_chain u_idc_chain (.mclk(mclk), .rst_b(rst_b), .link(link), .cio_req(cio_req),
        .chan_req(chan_req), .chan_cause(chan_cause), .attn_strobe(attn_strobe),
        .attn_port(attn_port), .attention_port_jumper(attention_port_jumper),
        .channel_attention(channel_attention), .sys_int_req(sys_int_req),
        .bus_irq_level_jumper(bus_irq_level_jumper), .bus_irq(bus_irq), .bus_req(bus_req),
        .bus_priority_in(bus_priority_in), .bus_priority_out(bus_priority_out),
        .bus_grant(bus_grant), .early_memory_acknowledge(early_memory_acknowledge),
        .normal_mem_ack(normal_mem_ack), .early_ack_jumper(early_ack_jumper),
        .mem_ack(mem_ack), .master_board_jumper(master_board_jumper), .is_master(is_master));
    idc_host u_idc_host (.mclk(mclk), .rst_b(rst_b), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    idc_monitor u_idc_monitor (.mclk(mclk), .rst_b(rst_b), .int_req(link.int_req),
        .iack(link.iack), .vec_valid(link.vec_valid), .vec(link.vec), .eoi(link.eoi),
        .prog_we(link.prog_we), .prog_sel(link.prog_sel), .prog_data(link.prog_data));
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // bus cycles; each starts on a fresh edge so a strobe never drops and rises at once
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // one-cycle source pulses with fresh random causes; the model marks them pending
    task automatic pulse(input logic [4:0] c, input logic [9:0] h);
        @(posedge mclk);
        cio_req <= c;
        chan_req <= h;
        chan_cause <= 20'($urandom);
        @(posedge mclk);
        cio_req <= '0;
        chan_req <= '0;
        for (int i = 0; i < 5; i++) pend[i] |= c[i];
        for (int i = 0; i < 10; i++) pend[14 - i] |= h[i];
    endtask
    // expected vector of chain position s (0..4 counter/io, then channels 9 down to 0)
    function automatic logic [7:0] expv(input int s);
        int ch;
        int c;
        ch = 14 - s;
        c = (s < 5) ? 0 : 1 + (9 - ch) / 2;
        if (!sav)
            return base[c];
        if (s < 5)
            return {base[c][7:3], 3'(s)};
        return {base[c][7:3], ch[0] == 1'b0, chan_cause[2 * ch +: 2]};
    endfunction
    // waits, bounded, for the next vector and checks it against the highest pending source
    task automatic take();
        int s;
        int n;
        s = 0;
        while (s < 14 && !pend[s]) s++;
        for (n = 0; n < 30; n++)
        begin
            cyc(1);
            if (link.vec_valid === 1'b1)
                break;
        end
        if (n == 30)
        begin
            fail_count++;
            give_verdict();
        end
        else
        begin
            lastv = expv(s);
            chk(link.vec, lastv);
            pend[s] = 1'b0;
            acks++;
        end
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] d;
        {rst_b, wr, rd, attn_strobe, sys_int_req, bus_req, bus_priority_in} = '0;
        {early_memory_acknowledge, normal_mem_ack, early_ack_jumper, master_board_jumper} = '0;
        {addr, attn_port, attention_port_jumper, wdata, bus_irq_level_jumper} = '0;
        {cio_req, chan_req, chan_cause} = '0;
        fail_count = 0;
        compares = 0;
        acks = 0;
        void'($urandom(32'hD8AF));
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        rreg(IDC_REG_STAT, d);
        chk(d, 8'h00);
        // distinct random bases, far from the reserved range
        for (int i = 0; i < 6; i++)
        begin
            base[i] = 8'h28 + 8'(i * 32) + 8'($urandom_range(0, 7));
            wreg(4'(i), base[i]);
        end
        // refused codes flag an error and leave the base alone
        for (int i = 0; i < 3; i++)
        begin
            wreg(4'h0, bad[i]);
            rreg(IDC_REG_STAT, d);
            chk(d, 8'h01);
            wreg(IDC_REG_STAT, 8'h01);
        end
        // every source at once, served in chain order, plain and cause-folded vectors
        for (int m = 0; m < 2; m++)
        begin
            sav = m[0];
            wreg(IDC_REG_CTRL, {7'h0, sav});
            pulse(5'h1F, 10'h3FF);
            repeat (15)
            begin
                take();
                wreg(IDC_REG_EOI, 8'h00);
            end
        end
        // a lower request stays hidden while a higher source is in service
        pulse(5'h00, 10'h200);
        take();
        pulse(5'h00, 10'h001);
        cyc(3);
        rreg(IDC_REG_STAT, d);
        chk(d, 8'h02);
        wreg(IDC_REG_EOI, 8'h00);
        take();
        wreg(IDC_REG_EOI, 8'h00);
        // attention only on the jumpered port, and it raises the input-port source
        @(posedge mclk);
        attention_port_jumper <= 4'($urandom);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge mclk);
            attn_port <= attention_port_jumper ^ 4'(1 - i);
            attn_strobe <= 1'b1;
            @(posedge mclk);
            attn_strobe <= 1'b0;
            #1;
            chk({7'h0, channel_attention}, 8'(i));
        end
        pend[1] = 1'b1;
        take();
        wreg(IDC_REG_EOI, 8'h00);
        // jumper table walked through eight settings, covering every value of each field
        for (int i = 0; i < 8; i++)
        begin
            @(posedge mclk);
            sys_int_req <= 1'b1;
            bus_irq_level_jumper <= 3'(i);
            {bus_req, bus_priority_in} <= 2'(i);
            {early_ack_jumper, early_memory_acknowledge, normal_mem_ack} <= 3'(i);
            master_board_jumper <= i[0];
            cyc(2);
            chk(bus_irq, 8'h01 << i);
            chk({6'h0, bus_grant, bus_priority_out}, {6'h0, i[0] & i[1], i[0] & ~i[1]});
            chk({7'h0, mem_ack}, {7'h0, i[2] ? i[1] : i[0]});
            chk({7'h0, is_master}, {7'h0, i[0]});
        end
        rreg(IDC_REG_CNT, d);
        chk(d, 8'(acks));
        rreg(IDC_REG_VEC, d);
        chk(d, lastv);
        give_verdict();
    end
endmodule
